// ===== rtl/host_port_pkg.sv
// Shared constants and types for the multi-mode host bus port
`default_nettype none
package host_port_pkg;
   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int TYPE_W = 3;

   // ---------------------------------------------------------------
   // Host type select codes
   // ---------------------------------------------------------------
   localparam logic [TYPE_W-1:0] TYPE_ASYNC_SEP = 3'h0;
   localparam logic [TYPE_W-1:0] TYPE_ASYNC_DS = 3'h3;
   localparam logic [TYPE_W-1:0] TYPE_SYNC_HIGH = 3'h7;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 4;
   localparam int HOST_CLK_MAX_MHZ = 33;
   // Shortest host clock period, rounded down
   localparam int HOST_CLK_MIN_PERIOD_NS = 1000 / HOST_CLK_MAX_MHZ;
   localparam int HOST_CLK_MIN_CYCLES = HOST_CLK_MIN_PERIOD_NS / SYS_CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Internal storage map
   // ---------------------------------------------------------------
   localparam int MEM_DEPTH_DEFAULT = 256;
   localparam logic [DATA_W-1:0] MEM_RESET_VALUE = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_ASYNC_SEP,
      MODE_ASYNC_DS,
      MODE_SYNC
   } host_mode_t;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ACCESS,
      PH_DONE
   } phase_t;

   typedef struct packed {
      logic rst_n;
      logic hclk;
      logic cs_n;
      logic rw_n;
      logic strobe_n;
      logic data_bus_enable_n_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } host_pins_t;

   localparam int PINS_W = $bits(host_pins_t);
   // Idle pin levels: strobes and selects negated, device reset released
   localparam host_pins_t PINS_IDLE = '{rst_n: 1'b1, hclk: 1'b0, cs_n: 1'b1, rw_n: 1'b1,
      strobe_n: 1'b1, data_bus_enable_n_n: 1'b1, addr: '0, data: '0};

   function automatic host_mode_t decode_type(input logic [TYPE_W-1:0] code);
      if (code == TYPE_ASYNC_SEP) begin
         return MODE_ASYNC_SEP;
      end else if (code == TYPE_ASYNC_DS) begin
         return MODE_ASYNC_DS;
      end
      // All remaining codes, TYPE_SYNC_HIGH among them, are clocked styles
      return MODE_SYNC;
   endfunction : decode_type
endpackage : host_port_pkg
`default_nettype wire

// ===== rtl/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Pins
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // Stage 0 feeds stage 1 only
   logic [1:0][WIDTH-1:0] stage;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         stage <= {RESET_VALUE, RESET_VALUE};
      end else begin
         stage <= {stage[0], async_in};
      end
   end

   assign sync_out = stage[1];
endmodule : pin_sync
`default_nettype wire

// ===== rtl/multi_mode_host_bus_port.sv
// Host bus slave port with strobe-driven and host-clocked bus styles
`default_nettype none
module multi_mode_host_bus_port #(
   parameter int MEM_DEPTH = host_port_pkg::MEM_DEPTH_DEFAULT
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Device reset and strap
   input wire logic reset_n_in,
   input wire logic [host_port_pkg::TYPE_W-1:0] host_type_select_in,
   // Host control pins
   input wire logic host_bus_clk_in,
   input wire logic chip_select_pin_n_in,
   input wire logic write_strobe_n_in,
   input wire logic read_strobe_pin_n_in,
   input wire logic data_bus_enable_n_in,
   input wire logic [host_port_pkg::ADDR_W-1:0] host_addr_in,
   // Data bus
   input wire logic [host_port_pkg::DATA_W-1:0] host_data_bus_in,
   output logic [host_port_pkg::DATA_W-1:0] host_data_bus_out,
   output logic host_data_bus_oe_out,
   // Acknowledge
   output logic ready_pin_n_out,
   output logic ready_pin_oe_out
);
   import host_port_pkg::*;

   localparam int MEM_AW = $clog2(MEM_DEPTH);

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   host_pins_t pins_raw;
   host_pins_t pins;

   always_comb begin
      pins_raw.rst_n = reset_n_in;
      pins_raw.hclk = host_bus_clk_in;
      pins_raw.cs_n = chip_select_pin_n_in;
      pins_raw.rw_n = write_strobe_n_in;
      pins_raw.strobe_n = read_strobe_pin_n_in;
      pins_raw.data_bus_enable_n_n = data_bus_enable_n_in;
      pins_raw.addr = host_addr_in;
      pins_raw.data = host_data_bus_in;
   end

   pin_sync #(
      .WIDTH(PINS_W),
      .RESET_VALUE(PINS_IDLE)
   ) u_pin_sync (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      host_mode_t mode;
      phase_t phase;
      logic is_read;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic drive;
      logic prev_hclk;
      logic prev_strobe_n;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
      logic ack_n;
      logic ack_oe;
   } state_t;

   state_t st;
   state_t next_st;

   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic dev_rst;
   logic hclk_rise;
   logic strobe_fall;
   logic hit;
   logic [DATA_W-1:0] lookup;

   // Device reset pin acts through the synchroniser, so its release is clean
   assign dev_rst = sys_rst_in | ~pins.rst_n;

   // Host clock is a plain input; 250 MHz sampling sees every 33 MHz edge
   assign hclk_rise = pins.hclk & ~st.prev_hclk;
   assign strobe_fall = ~pins.strobe_n & st.prev_strobe_n;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   always_comb begin
      hit = (st.addr < ADDR_W'(MEM_DEPTH));
      lookup = UNMAPPED_READ;
      if (hit) begin
         lookup = mem[st.addr[MEM_AW-1:0]];
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      wr_en = 1'b0;
      wr_addr = st.addr;
      wr_data = st.wdata;
      next_st.prev_hclk = pins.hclk;
      next_st.prev_strobe_n = pins.strobe_n;
      next_st.ack_oe = 1'b1;

      unique case (st.mode)
         MODE_ASYNC_SEP: begin
            // Host clock is not looked at in this mode
            unique case (st.phase)
               PH_IDLE: begin
                  if (!pins.cs_n && !pins.strobe_n) begin
                     next_st.addr = pins.addr;
                     next_st.is_read = 1'b1;
                     next_st.phase = PH_ACCESS;
                  end else if (!pins.cs_n && !pins.rw_n) begin
                     next_st.addr = pins.addr;
                     next_st.is_read = 1'b0;
                     next_st.wdata = pins.data;
                     next_st.phase = PH_ACCESS;
                  end
               end
               PH_ACCESS: begin
                  next_st.rdata = lookup;
                  next_st.drive = st.is_read;
                  next_st.ack_n = 1'b0;
                  next_st.phase = PH_DONE;
                  if (!st.is_read && !pins.rw_n) begin
                     next_st.wdata = pins.data;
                  end
               end
               PH_DONE: begin
                  if (st.is_read) begin
                     if (pins.strobe_n || pins.cs_n) begin
                        next_st.drive = 1'b0;
                        next_st.ack_n = 1'b1;
                        next_st.phase = PH_IDLE;
                     end
                  end else if (pins.cs_n) begin
                     // Select lost before the strobe closed: drop the write
                     next_st.ack_n = 1'b1;
                     next_st.phase = PH_IDLE;
                  end else if (pins.rw_n) begin
                     wr_en = hit;
                     next_st.ack_n = 1'b1;
                     next_st.phase = PH_IDLE;
                  end else begin
                     next_st.wdata = pins.data;
                  end
               end
               default: begin
                  next_st.phase = PH_IDLE;
               end
            endcase
            next_st.data_out = next_st.rdata;
            next_st.data_oe = next_st.drive & ~pins.data_bus_enable_n_n;
         end

         MODE_ASYNC_DS: begin
            unique case (st.phase)
               PH_IDLE: begin
                  if (!pins.cs_n && strobe_fall) begin
                     next_st.addr = pins.addr;
                     // Direction pin high means read
                     next_st.is_read = pins.rw_n;
                     next_st.wdata = pins.data;
                     next_st.phase = PH_ACCESS;
                  end
               end
               PH_ACCESS: begin
                  next_st.rdata = lookup;
                  next_st.drive = st.is_read;
                  next_st.ack_n = 1'b0;
                  next_st.phase = PH_DONE;
                  next_st.wdata = pins.data;
               end
               PH_DONE: begin
                  if (pins.cs_n) begin
                     next_st.drive = 1'b0;
                     next_st.ack_n = 1'b1;
                     next_st.phase = PH_IDLE;
                  end else if (pins.strobe_n) begin
                     // Write data is the level seen just before the strobe rose
                     wr_en = ~st.is_read & hit;
                     next_st.drive = 1'b0;
                     next_st.ack_n = 1'b1;
                     next_st.phase = PH_IDLE;
                  end else begin
                     next_st.wdata = pins.data;
                  end
               end
               default: begin
                  next_st.phase = PH_IDLE;
               end
            endcase
            next_st.data_out = next_st.rdata;
            next_st.data_oe = next_st.drive & ~pins.data_bus_enable_n_n;
         end

         MODE_SYNC: begin
            // Every output change except the ready enable turning on after reset waits for a host clock rise
            if (hclk_rise) begin
               unique case (st.phase)
                  PH_IDLE: begin
                     if (!pins.cs_n) begin
                        if (!pins.rw_n) begin
                           next_st.addr = pins.addr;
                           if (!pins.strobe_n) begin
                              wr_addr = pins.addr;
                              wr_data = pins.data;
                              wr_en = (pins.addr < ADDR_W'(MEM_DEPTH));
                              next_st.ack_n = 1'b0;
                              next_st.phase = PH_DONE;
                           end
                        end else begin
                           next_st.is_read = 1'b1;
                           next_st.rdata = lookup;
                           next_st.phase = PH_ACCESS;
                        end
                     end
                  end
                  PH_ACCESS: begin
                     next_st.drive = 1'b1;
                     next_st.ack_n = 1'b0;
                     next_st.phase = PH_DONE;
                  end
                  PH_DONE: begin
                     next_st.drive = 1'b0;
                     next_st.is_read = 1'b0;
                     next_st.ack_n = 1'b1;
                     next_st.phase = PH_IDLE;
                  end
                  default: begin
                     next_st.phase = PH_IDLE;
                  end
               endcase
               next_st.data_out = next_st.rdata;
               next_st.data_oe = next_st.drive & ~pins.data_bus_enable_n_n;
            end
         end

         default: begin
            next_st.mode = MODE_SYNC;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (dev_rst) begin
         st <= '0;
         // Strap is taken each reset cycle, so the last one before release holds
         st.mode <= decode_type(host_type_select_in);
         st.phase <= PH_IDLE;
         st.prev_hclk <= 1'b0;
         st.prev_strobe_n <= 1'b1;
         st.ack_n <= 1'b1;
         st.ack_oe <= 1'b0;
         st.data_oe <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Storage cleared by reset; a large depth makes this reset costly
   always_ff @(posedge sys_clk_in) begin
      if (dev_rst) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] <= MEM_RESET_VALUE;
         end
      end else if (wr_en) begin
         mem[wr_addr[MEM_AW-1:0]] <= wr_data;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign host_data_bus_out = st.data_out;
   assign host_data_bus_oe_out = st.data_oe;
   assign ready_pin_n_out = st.ack_n;
   assign ready_pin_oe_out = st.ack_oe;
endmodule : multi_mode_host_bus_port
`default_nettype wire

// ===== verification/host_port_checker.sv
// Pin-level assertions for the multi-mode host bus port
`default_nettype none
module host_port_checker (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Observed pins
   input wire logic reset_n_in,
   input wire logic [host_port_pkg::TYPE_W-1:0] host_type_select_in,
   input wire logic host_bus_clk_in,
   input wire logic chip_select_pin_n_in,
   input wire logic write_strobe_n_in,
   input wire logic read_strobe_pin_n_in,
   input wire logic data_bus_enable_n_in,
   input wire logic [host_port_pkg::ADDR_W-1:0] host_addr_in,
   input wire logic [host_port_pkg::DATA_W-1:0] host_data_bus_in,
   input wire logic [host_port_pkg::DATA_W-1:0] host_data_bus_out,
   input wire logic host_data_bus_oe_out,
   input wire logic ready_pin_n_out,
   input wire logic ready_pin_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import host_port_pkg::*;
   logic sep_mode;
   logic clk_mode;
   logic hclk_prev;
   logic [7:0] cs_hist;
   logic [7:0] rise_hist;
   // Select level at the last two host clock rises; a clocked read answers one rise later
   logic [1:0] cs_at_rise;
   assign sep_mode = host_type_select_in == TYPE_ASYNC_SEP;
   assign clk_mode = !sep_mode && host_type_select_in != TYPE_ASYNC_DS;
   // -------------------------------------------
   // Recent history, covers the pin sync delay
   // -------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      cs_hist <= {cs_hist[6:0], !chip_select_pin_n_in};
      hclk_prev <= host_bus_clk_in;
      rise_hist <= {rise_hist[6:0], host_bus_clk_in && !hclk_prev};
      if (host_bus_clk_in && !hclk_prev) begin
         cs_at_rise <= {cs_at_rise[0], !chip_select_pin_n_in};
      end
   end
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_strobes_idle;
      sep_mode && reset_n_in && read_strobe_pin_n_in && write_strobe_n_in;
   endsequence
   sequence s_read_held;
      sep_mode && reset_n_in && !chip_select_pin_n_in && !read_strobe_pin_n_in;
   endsequence
   sequence s_dev_reset;
      !reset_n_in;
   endsequence
   a_release_ready: assert property ($fell(sys_rst_in) |->
      !host_data_bus_oe_out && !ready_pin_oe_out ##1 ready_pin_oe_out && ready_pin_n_out)
      else $error("ready pin wrong after reset release");
   a_dev_float: assert property (s_dev_reset [*5] |=>
      !host_data_bus_oe_out && !ready_pin_oe_out && ready_pin_n_out)
      else $error("outputs not floated by device reset");
   a_oe_with_ready: assert property (host_data_bus_oe_out |->
      !ready_pin_n_out && ready_pin_oe_out)
      else $error("data driven without acknowledge");
   a_cs_gate: assert property ($fell(ready_pin_n_out) |->
      (clk_mode ? |cs_at_rise : |cs_hist))
      else $error("acknowledge without chip select");
   a_sep_answer: assert property (s_read_held [*5] |-> !ready_pin_n_out)
      else $error("read strobe not acknowledged in time");
   a_sep_release: assert property (s_strobes_idle [*5] |=>
      ready_pin_n_out && !host_data_bus_oe_out)
      else $error("bus not released after strobes");
   a_bus_gate: assert property ((sep_mode && data_bus_enable_n_in) [*5] |->
      !host_data_bus_oe_out)
      else $error("data bus driven while enable high");
   a_clk_edges: assert property (clk_mode && reset_n_in &&
      ($changed(ready_pin_n_out) || $changed(host_data_bus_oe_out)) |-> |rise_hist)
      else $error("clocked mode output moved away from host clock edge");
endmodule : host_port_checker
bind multi_mode_host_bus_port host_port_checker checker_inst (
   .sys_clk_in, .sys_rst_in, .reset_n_in, .host_type_select_in, .host_bus_clk_in,
   .chip_select_pin_n_in, .write_strobe_n_in, .read_strobe_pin_n_in,
   .data_bus_enable_n_in, .host_addr_in, .host_data_bus_in, .host_data_bus_out,
   .host_data_bus_oe_out, .ready_pin_n_out, .ready_pin_oe_out
);
`default_nettype wire

// ===== verification/host_model.sv
// Behavioural host processor driving the port pins
`default_nettype none
module host_model (
   // Clock
   input wire logic sys_clk_in,
   // Device side
   input wire logic [host_port_pkg::DATA_W-1:0] dev_data_in,
   input wire logic dev_oe_in,
   input wire logic ready_n_in,
   input wire logic ready_oe_in,
   // Host pins
   output logic hclk_out,
   output logic cs_n_out,
   output logic wr_n_out,
   output logic strobe_n_out,
   output logic bus_en_n_out,
   output logic [host_port_pkg::ADDR_W-1:0] addr_out,
   output logic [host_port_pkg::DATA_W-1:0] bus_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import host_port_pkg::*;
   // Half host period in system cycles: 15.6 MHz, under the limit
   localparam int HALF = 8;
   logic drive;
   logic ready_lvl;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] last = '0;
   // Released bus toggles so a stale byte never reads as valid
   assign bus_out = dev_oe_in ? dev_data_in : (drive ? wdata : ~last);
   // Ready pin assumed pulled up on the board
   assign ready_lvl = ready_oe_in ? ready_n_in : 1'b1;
   always @(posedge sys_clk_in) last <= bus_out;
   initial begin
      hclk_out = 1'b0;
      cs_n_out = 1'b1;
      wr_n_out = 1'b1;
      strobe_n_out = 1'b1;
      bus_en_n_out = 1'b1;
      addr_out = '0;
      drive = 1'b0;
      wdata = '0;
   end
   task automatic async_acc(input logic strb, input logic rd, input logic sel,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic ack, output logic [DATA_W-1:0] q);
      ack = 1'b0;
      q = '0;
      cs_n_out = !sel;
      addr_out = a;
      wr_n_out = rd;
      wdata = d;
      drive = !rd;
      @(negedge sys_clk_in);
      strobe_n_out = !(rd || strb);
      bus_en_n_out = !rd;
      for (int i = 0; i < 40 && !ack; i++) begin
         @(posedge sys_clk_in);
         ack = !ready_lvl;
         q = bus_out;
      end
      @(negedge sys_clk_in);
      strobe_n_out = 1'b1;
      wr_n_out = 1'b1;
      bus_en_n_out = 1'b1;
      // Data held past the strobe rise until ready returns
      for (int i = 0; i < 20 && !ready_lvl; i++) @(negedge sys_clk_in);
      cs_n_out = 1'b1;
      drive = 1'b0;
      @(negedge sys_clk_in);
   endtask : async_acc
   task automatic clk_cycle(input logic cs, input logic rw, input logic we, input logic en,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic ack, output logic [DATA_W-1:0] q);
      cs_n_out = !cs;
      wr_n_out = rw;
      strobe_n_out = !we;
      bus_en_n_out = !en;
      addr_out = a;
      wdata = d;
      drive = cs && !rw && we;
      repeat (HALF) @(negedge sys_clk_in);
      ack = !ready_lvl;
      q = bus_out;
      hclk_out = 1'b1;
      repeat (HALF) @(negedge sys_clk_in);
      hclk_out = 1'b0;
   endtask : clk_cycle
endmodule : host_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the multi-mode host bus port
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import host_port_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic dev_rst_n = 1'b1;
   logic [TYPE_W-1:0] type_sel = TYPE_ASYNC_SEP;
   logic [TYPE_W-1:0] codes [2] = '{TYPE_SYNC_HIGH, 3'h4};
   logic hclk, cs_n, wr_n, strobe_n, en_n, doe, rdy_n, rdy_oe, ack;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] bus, dout, q;
   logic [DATA_W-1:0] shadow [MEM_DEPTH_DEFAULT];
   int miscompares = 0;
   int checked = 0;
   always #(SYS_CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   host_model host (.sys_clk_in(sys_clk), .dev_data_in(dout), .dev_oe_in(doe),
      .ready_n_in(rdy_n), .ready_oe_in(rdy_oe), .hclk_out(hclk), .cs_n_out(cs_n),
      .wr_n_out(wr_n), .strobe_n_out(strobe_n), .bus_en_n_out(en_n), .addr_out(addr),
      .bus_out(bus));
   multi_mode_host_bus_port #(.MEM_DEPTH(MEM_DEPTH_DEFAULT)) uut (.sys_clk_in(sys_clk),
      .sys_rst_in(sys_rst), .reset_n_in(dev_rst_n), .host_type_select_in(type_sel),
      .host_bus_clk_in(hclk), .chip_select_pin_n_in(cs_n), .write_strobe_n_in(wr_n),
      .read_strobe_pin_n_in(strobe_n), .data_bus_enable_n_in(en_n), .host_addr_in(addr),
      .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe_out(doe),
      .ready_pin_n_out(rdy_n), .ready_pin_oe_out(rdy_oe));
   // ---------------------------------
   // Checking and expectation helpers
   // ---------------------------------
   task automatic check(input string what, input logic [DATA_W-1:0] seen,
      input logic [DATA_W-1:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [DATA_W-1:0] expect_read(input logic [ADDR_W-1:0] a);
      return (a < MEM_DEPTH_DEFAULT) ? shadow[a[7:0]] : UNMAPPED_READ;
   endfunction : expect_read
   task automatic end_of_test();
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   task automatic restart(input logic [TYPE_W-1:0] code);
      @(negedge sys_clk);
      type_sel = code;
      sys_rst = 1'b1;
      repeat (3) @(negedge sys_clk);
      sys_rst = 1'b0;
      foreach (shadow[i]) shadow[i] = MEM_RESET_VALUE;
      @(negedge sys_clk);
      check("ready drive", {6'h00, rdy_oe, rdy_n}, 8'h03);
      repeat (4) @(negedge sys_clk);
   endtask : restart
   // Style 0 separate strobes, 1 data strobe, 2 host clocked
   task automatic access(input int style, input logic rd, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      logic k;
      logic [DATA_W-1:0] r;
      if (style == 2) begin
         host.clk_cycle(1'b1, 1'b0, !rd, 1'b0, a, d, k, r);
         if (rd) host.clk_cycle(1'b1, 1'b1, 1'b0, 1'b1, a, d, k, r);
         if (rd) host.clk_cycle(1'b0, 1'b1, 1'b0, 1'b1, a, d, k, r);
         host.clk_cycle(1'b0, 1'b1, 1'b0, rd, a, d, k, r);
      end else begin
         host.async_acc(style == 1, rd, 1'b1, a, d, k, r);
      end
      check("acknowledge", {7'h00, k}, 8'h01);
      if (rd) check("read data", r, expect_read(a));
      else if (a < MEM_DEPTH_DEFAULT) shadow[a[7:0]] = d;
   endtask : access
   task automatic random_ops(input int style, input int n);
      logic [ADDR_W-1:0] a;
      for (int i = 0; i < n; i++) begin
         // Small pool makes reads hit earlier writes
         a = ($urandom % 4 == 0) ? ADDR_W'($urandom) : ADDR_W'($urandom % 8);
         access(style, 1'($urandom), a, DATA_W'($urandom));
      end
   endtask : random_ops
   initial begin
      void'($urandom(28));
      restart(TYPE_ASYNC_SEP);
      access(0, 1'b0, 15'h00ff, 8'ha5);
      access(0, 1'b0, 15'h0100, 8'h5a);
      access(0, 1'b1, 15'h0100, 8'h00);
      access(0, 1'b1, 15'h00ff, 8'h00);
      access(0, 1'b1, 15'h7fff, 8'h00);
      random_ops(0, 40);
      host.async_acc(1'b0, 1'b0, 1'b0, 15'h0003, 8'h3c, ack, q);
      check("deselected acknowledge", {7'h00, ack}, 8'h00);
      access(0, 1'b1, 15'h0003, 8'h00);
      @(negedge sys_clk);
      dev_rst_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      check("floated outputs", {6'h00, doe, rdy_oe}, 8'h00);
      dev_rst_n = 1'b1;
      foreach (shadow[i]) shadow[i] = MEM_RESET_VALUE;
      repeat (4) @(negedge sys_clk);
      access(0, 1'b1, 15'h00ff, 8'h00);
      restart(TYPE_ASYNC_DS);
      random_ops(1, 30);
      foreach (codes[i]) begin
         restart(codes[i]);
         random_ops(2, 10);
      end
      end_of_test();
   end
   // Whole run needs about 8 us
   initial begin
      #100us;
      miscompares++;
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
